// File: rpf_packet_filter.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - bit 6 of each debug pin register inverts that pin's output
// - bits 5..0 pick the internal signal on each debug pin, reset zero
// - bit 7 of the middle debug register picks minimum or maximum drive
// - sync word is high byte d3 and low byte 91 after reset
// - fixed mode takes payload length from the length register
// - variable mode treats the length register as the maximum length
// - quality count rises one per toggling bit, falls eight per repeat
// - sync accepted only when quality count reaches four times threshold
// - a zero threshold accepts every sync word
// - append bit adds signal strength and link quality/crc status bytes
// - filter mode 00 accepts all, 01 only own address
// - filter mode 10 also accepts broadcast address 00
// - filter mode 11 also accepts broadcast addresses 00 and ff
// - own address comes from the device address register, reset 00
// - variable mode reads length from the first byte after sync
module rpf_packet_filter import rpf_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        rxStart,
  input  wire logic        rxBitValid,
  input  wire logic        rxBit,
  input  wire logic [7:0]  rssiValue,
  input  wire logic [6:0]  lqiValue,
  input  wire logic        crcOk,
  output var  logic [7:0]  rxData,
  output var  logic        rxDataValid,
  output var  logic        rxPacketEnd,
  output var  logic        rxDrop,
  output var  logic        debugPinC,
  output var  logic        debugPinB,
  output var  logic        debugPinA,
  output var  logic        debugDriveMax
);
  logic [7:0]  syncHi_q,   syncHi_d;
  logic [7:0]  syncLo_q,   syncLo_d;
  logic [7:0]  packet_length_limit_q,   packet_length_limit_d;
  logic [7:0]  filtCtrl_q, filtCtrl_d;
  logic [7:0]  lenCtrl_q,  lenCtrl_d;
  logic [7:0]  devAddr_q,  devAddr_d;
  logic [7:0]  dbgCfg_q [3], dbgCfg_d [3];
  logic        dropSeen_q, dropSeen_d;
  logic [31:0] prdata_q,   prdata_d;
  logic        pready_q,   pready_d;
  logic        pslverr_q,  pslverr_d;
  logic [15:0] regIdx;
  logic        mapped;
  logic        wrEn;
  logic [7:0]  rdByte;

  rpf_state_t  state_q,    state_d;
  logic [15:0] shift_q,    shift_d;
  logic [2:0]  bitCnt_q,   bitCnt_d;
  logic [7:0]  remain_q,   remain_d;
  logic [7:0]  lenByte_q,  lenByte_d;
  logic [7:0]  addrHold_q, addrHold_d;
  logic        addrPend_q, addrPend_d;
  logic [7:0]  rxData_q,   rxData_d;
  logic        rxValid_q,  rxValid_d;
  logic        rxEnd_q,    rxEnd_d;
  logic        rxDrop_q,   rxDrop_d;
  logic [2:0]  dbgPin_q,   dbgPin_d;

  logic [15:0] shiftNext;
  logic [7:0]  newByte;
  logic        byteDone;
  logic        pqReached;
  logic        syncMatch;
  logic        syncHit;
  logic        addrOk;
  logic [2:0]  qualThresh;
  logic [1:0]  adrMode;
  logic        appendOn;
  logic        varMode;
  logic        filterOn;

  assign qualThresh = filtCtrl_q[THR_MSB:THR_LSB];
  assign adrMode  = filtCtrl_q[ADR_MSB:0];
  assign appendOn = filtCtrl_q[APPEND_BIT];
  // reserved length codes behave as fixed length
  assign varMode  = lenCtrl_q[LEN_MODE_MSB:0] == LEN_VAR;
  assign filterOn = adrMode != ADR_NONE;

  // ==========================================================
  // apb slave: one wait state, registered answer
  assign regIdx = paddr[17:2];
  assign wrEn   = psel && penable && pready_q && pwrite && !pslverr_q;

  always_comb begin
    mapped = paddr[1:0] == 2'h0;
    rdByte = 8'h00;
    unique case (regIdx)
      IDX_SYNC_HI:   rdByte = syncHi_q;
      IDX_SYNC_LO:   rdByte = syncLo_q;
      IDX_PKT_LEN:   rdByte = packet_length_limit_q;
      IDX_FILT_CTRL: rdByte = filtCtrl_q;
      IDX_LEN_CTRL:  rdByte = lenCtrl_q;
      IDX_DEV_ADDR:  rdByte = devAddr_q;
      IDX_DBG_C:     rdByte = dbgCfg_q[2];
      IDX_DBG_B:     rdByte = dbgCfg_q[1];
      IDX_DBG_A:     rdByte = dbgCfg_q[0];
      IDX_RX_STAT:   rdByte = {5'h00, dropSeen_q, pqReached,
                               state_q != ST_HUNT};
      default:       mapped = 1'b0;
    endcase
  end

  always_comb begin
    pready_d   = psel && penable && !pready_q;
    pslverr_d  = pready_d && !mapped;
    prdata_d   = pready_d ? {24'h0, mapped ? rdByte : 8'h00} : 32'h0;
    syncHi_d   = syncHi_q;
    syncLo_d   = syncLo_q;
    packet_length_limit_d   = packet_length_limit_q;
    filtCtrl_d = filtCtrl_q;
    lenCtrl_d  = lenCtrl_q;
    devAddr_d  = devAddr_q;
    dbgCfg_d   = dbgCfg_q;
    // hardware set wins over a clearing write in the same cycle
    dropSeen_d = (dropSeen_q && !(wrEn && regIdx == IDX_RX_STAT))
                 || rxDrop_q;
    if (wrEn) begin
      unique case (regIdx)
        IDX_SYNC_HI:   syncHi_d   = pwdata[7:0];
        IDX_SYNC_LO:   syncLo_d   = pwdata[7:0];
        IDX_PKT_LEN:   packet_length_limit_d   = pwdata[7:0];
        IDX_FILT_CTRL: filtCtrl_d = pwdata[7:0] & MSK_FILT_CTRL;
        IDX_LEN_CTRL:  lenCtrl_d  = pwdata[7:0] & MSK_LEN_CTRL;
        IDX_DEV_ADDR:  devAddr_d  = pwdata[7:0];
        IDX_DBG_C:     dbgCfg_d[2] = pwdata[7:0] & MSK_DBG_CA;
        IDX_DBG_B:     dbgCfg_d[1] = pwdata[7:0] & MSK_DBG_B;
        IDX_DBG_A:     dbgCfg_d[0] = pwdata[7:0] & MSK_DBG_CA;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      prdata_q   <= 32'h0;
      syncHi_q   <= RST_SYNC_HI;
      syncLo_q   <= RST_SYNC_LO;
      packet_length_limit_q   <= RST_PKT_LEN;
      filtCtrl_q <= RST_FILT_CTRL;
      lenCtrl_q  <= RST_LEN_CTRL;
      devAddr_q  <= RST_DEV_ADDR;
      dbgCfg_q   <= '{RST_DBG, RST_DBG, RST_DBG};
      dropSeen_q <= 1'b0;
    end else begin
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      prdata_q   <= prdata_d;
      syncHi_q   <= syncHi_d;
      syncLo_q   <= syncLo_d;
      packet_length_limit_q   <= packet_length_limit_d;
      filtCtrl_q <= filtCtrl_d;
      lenCtrl_q  <= lenCtrl_d;
      devAddr_q  <= devAddr_d;
      dbgCfg_q   <= dbgCfg_d;
      dropSeen_q <= dropSeen_d;
    end
  end

  // ==========================================================
  // preamble quality and sync search
  rpf_preamble_qual u_pq (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .restart    (rxStart),
    .bitValid   (rxBitValid),
    .bitIn      (rxBit),
    .threshold  (qualThresh),
    .qualityMet (pqReached)
  );

  assign shiftNext = {shift_q[14:0], rxBit};
  assign newByte   = shiftNext[7:0];
  assign byteDone  = rxBitValid && bitCnt_q == 3'h7;
  assign syncMatch = rxBitValid && shiftNext == {syncHi_q, syncLo_q};
  assign syncHit   = state_q == ST_HUNT && syncMatch && !rxStart
                     && (qualThresh == 3'h0 || pqReached);
  assign addrOk    = newByte == devAddr_q
                     || (adrMode[1] && newByte == BCAST_ZERO)
                     || (adrMode == ADR_BC0FF
                         && newByte == BCAST_ONES);

  // ==========================================================
  // packet sequencer; bytes arrive msb first
  always_comb begin
    state_d    = state_q;
    shift_d    = rxBitValid ? shiftNext : shift_q;
    bitCnt_d   = rxBitValid ? bitCnt_q + 3'h1 : bitCnt_q;
    remain_d   = remain_q;
    lenByte_d  = lenByte_q;
    addrHold_d = addrHold_q;
    addrPend_d = 1'b0;
    rxData_d   = rxData_q;
    rxValid_d  = 1'b0;
    rxEnd_d    = 1'b0;
    rxDrop_d   = 1'b0;
    if (addrPend_q) begin
      // held address goes out the cycle after the length byte
      rxData_d  = addrHold_q;
      rxValid_d = 1'b1;
    end
    unique case (state_q)
      ST_HUNT: begin
        bitCnt_d = 3'h0;
        if (syncHit) begin
          remain_d = packet_length_limit_q;
          if (varMode) state_d = ST_LEN;
          else if (packet_length_limit_q == 8'h00) state_d = ST_TAIL;
          else if (filterOn) state_d = ST_ADDR;
          else state_d = ST_PAYLOAD;
        end
      end
      ST_LEN: if (byteDone) begin
        lenByte_d = newByte;
        remain_d  = newByte;
        if (newByte > packet_length_limit_q) begin
          rxDrop_d = 1'b1;
          state_d  = ST_HUNT;
        end else if (newByte == 8'h00 || !filterOn) begin
          rxData_d  = newByte;
          rxValid_d = 1'b1;
          state_d   = newByte == 8'h00 ? ST_TAIL : ST_PAYLOAD;
        end else begin
          state_d = ST_ADDR;
        end
      end
      ST_ADDR: if (byteDone) begin
        remain_d = remain_q - 8'h01;
        state_d  = remain_q == 8'h01 ? ST_TAIL : ST_PAYLOAD;
        if (!addrOk) begin
          rxDrop_d = 1'b1;
          state_d  = ST_HUNT;
        end else if (varMode) begin
          rxData_d   = lenByte_q;
          rxValid_d  = 1'b1;
          addrHold_d = newByte;
          addrPend_d = 1'b1;
        end else begin
          rxData_d  = newByte;
          rxValid_d = 1'b1;
        end
      end
      ST_PAYLOAD: if (byteDone) begin
        rxData_d  = newByte;
        rxValid_d = 1'b1;
        remain_d  = remain_q - 8'h01;
        if (remain_q == 8'h01) state_d = ST_TAIL;
      end
      ST_TAIL: if (!addrPend_q) begin
        if (appendOn) begin
          rxData_d  = rssiValue;
          rxValid_d = 1'b1;
          state_d   = ST_STAT2;
        end else begin
          rxEnd_d = 1'b1;
          state_d = ST_HUNT;
        end
      end
      ST_STAT2: begin
        rxData_d  = {crcOk, lqiValue};
        rxValid_d = 1'b1;
        rxEnd_d   = 1'b1;
        state_d   = ST_HUNT;
      end
    endcase
    if (rxStart) begin
      state_d    = ST_HUNT;
      addrPend_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= ST_HUNT;
      shift_q    <= 16'h0;
      bitCnt_q   <= 3'h0;
      remain_q   <= 8'h00;
      lenByte_q  <= 8'h00;
      addrHold_q <= 8'h00;
      addrPend_q <= 1'b0;
      rxData_q   <= 8'h00;
      rxValid_q  <= 1'b0;
      rxEnd_q    <= 1'b0;
      rxDrop_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      shift_q    <= shift_d;
      bitCnt_q   <= bitCnt_d;
      remain_q   <= remain_d;
      lenByte_q  <= lenByte_d;
      addrHold_q <= addrHold_d;
      addrPend_q <= addrPend_d;
      rxData_q   <= rxData_d;
      rxValid_q  <= rxValid_d;
      rxEnd_q    <= rxEnd_d;
      rxDrop_q   <= rxDrop_d;
    end
  end

  // ==========================================================
  // debug pins: index 0 is pin a, 2 is pin c
  for (genvar i = 0; i < 3; i++) begin : g_dbg
    logic sig;
    always_comb begin
      unique case (dbgCfg_q[i][DBG_SEL_MSB:0])
        DSEL_ACTIVE: sig = state_q != ST_HUNT;
        DSEL_PQ:     sig = pqReached;
        DSEL_VALID:  sig = rxValid_q;
        DSEL_DROP:   sig = rxDrop_q;
        DSEL_END:    sig = rxEnd_q;
        default:     sig = 1'b0;
      endcase
      dbgPin_d[i] = sig ^ dbgCfg_q[i][DBG_INV_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dbgPin_q      <= 3'h0;
      debugDriveMax <= 1'b0;
    end else begin
      dbgPin_q      <= dbgPin_d;
      debugDriveMax <= dbgCfg_q[1][DRIVE_BIT];
    end
  end

  assign debugPinA   = dbgPin_q[0];
  assign debugPinB   = dbgPin_q[1];
  assign debugPinC   = dbgPin_q[2];
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign rxData      = rxData_q;
  assign rxDataValid = rxValid_q;
  assign rxPacketEnd = rxEnd_q;
  assign rxDrop      = rxDrop_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_two_status;
    rxValid_q && !rxEnd_q ##1 rxValid_q && rxEnd_q;
  endsequence

  a_sync_gated: assert property (
    (state_q == ST_HUNT && syncMatch && qualThresh != 3'h0 && !pqReached)
      |=> state_q == ST_HUNT)
    else $error("sync taken below quality threshold");
  a_sync_free: assert property (
    (state_q == ST_HUNT && syncMatch && qualThresh == 3'h0 && !rxStart)
      |=> state_q != ST_HUNT)
    else $error("sync refused with zero threshold");
  a_fixed_count: assert property (
    (syncHit && !varMode) |=> remain_q == $past(packet_length_limit_q))
    else $error("fixed length not loaded");
  a_len_limit: assert property (
    (state_q == ST_LEN && byteDone && newByte > packet_length_limit_q && !rxStart)
      |=> rxDrop_q && state_q == ST_HUNT && !rxValid_q)
    else $error("oversized packet not dropped");
  a_status_pair: assert property (
    (state_q == ST_TAIL && !addrPend_q && appendOn && !rxStart)
      |=> s_two_status)
    else $error("status bytes missing");
  a_addr_reject: assert property (
    (state_q == ST_ADDR && byteDone && !rxStart && newByte != devAddr_q
     && newByte != BCAST_ZERO && newByte != BCAST_ONES)
      |=> rxDrop_q ##1 !rxValid_q)
    else $error("foreign address not dropped");
  a_bcast_zero: assert property (
    (state_q == ST_ADDR && byteDone && !rxStart && adrMode == ADR_BC0
     && newByte == BCAST_ZERO) |=> !rxDrop_q && rxValid_q)
    else $error("broadcast zero refused");
  a_bcast_ones: assert property (
    (state_q == ST_ADDR && byteDone && !rxStart
     && newByte == BCAST_ONES)
      |=> rxDrop_q == (adrMode != ADR_BC0FF && devAddr_q != BCAST_ONES))
    else $error("broadcast ff handled wrongly");
  a_pin_invert: assert property (
    ($changed(dbgCfg_q[0][DBG_INV_BIT]) && $stable(dbgCfg_q[0][5:0])
     && $stable(g_dbg[0].sig)) |=> $changed(dbgPin_q[0]))
    else $error("invert bit had no effect on pin");
endmodule
`default_nettype wire

// File: rpf_pkg.sv
`default_nettype none
// ==========================================================
// register map and field layout
package rpf_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_SYNC_HI   = 16'hdf00;
  localparam logic [15:0] IDX_SYNC_LO   = 16'hdf01;
  localparam logic [15:0] IDX_PKT_LEN   = 16'hdf02;
  localparam logic [15:0] IDX_FILT_CTRL = 16'hdf03;
  localparam logic [15:0] IDX_LEN_CTRL  = 16'hdf04;
  localparam logic [15:0] IDX_DEV_ADDR  = 16'hdf05;
  localparam logic [15:0] IDX_DBG_C     = 16'hdf2f;
  localparam logic [15:0] IDX_DBG_B     = 16'hdf30;
  localparam logic [15:0] IDX_DBG_A     = 16'hdf31;
  localparam logic [15:0] IDX_RX_STAT   = 16'hdf3b;
  // reset values
  localparam logic [7:0] RST_SYNC_HI   = 8'hd3;
  localparam logic [7:0] RST_SYNC_LO   = 8'h91;
  localparam logic [7:0] RST_PKT_LEN   = 8'hff;
  localparam logic [7:0] RST_FILT_CTRL = 8'h04;
  localparam logic [7:0] RST_LEN_CTRL  = 8'h01;
  localparam logic [7:0] RST_DEV_ADDR  = 8'h00;
  localparam logic [7:0] RST_DBG       = 8'h00;
  // writable bits
  localparam logic [7:0] MSK_FILT_CTRL = 8'he7;
  localparam logic [7:0] MSK_LEN_CTRL  = 8'h03;
  localparam logic [7:0] MSK_DBG_CA    = 8'h7f;
  localparam logic [7:0] MSK_DBG_B     = 8'hff;
  // field positions
  localparam int DBG_INV_BIT  = 6;
  localparam int DBG_SEL_MSB  = 5;
  localparam int DRIVE_BIT    = 7;
  localparam int THR_MSB      = 7;
  localparam int THR_LSB      = 5;
  localparam int APPEND_BIT   = 2;
  localparam int ADR_MSB      = 1;
  localparam int LEN_MODE_MSB = 1;
  // address filter modes and length modes
  localparam logic [1:0] ADR_NONE  = 2'h0;
  localparam logic [1:0] ADR_OWN   = 2'h1;
  localparam logic [1:0] ADR_BC0   = 2'h2;
  localparam logic [1:0] ADR_BC0FF = 2'h3;
  localparam logic [1:0] LEN_VAR   = 2'h1;
  localparam logic [7:0] BCAST_ZERO = 8'h00;
  localparam logic [7:0] BCAST_ONES = 8'hff;
  // preamble quality estimator
  localparam logic [7:0] PQ_UP      = 8'h01;
  localparam logic [7:0] PQ_DOWN    = 8'h08;
  localparam logic [7:0] PQ_MAX     = 8'hff;
  // debug signal selector codes
  localparam logic [5:0] DSEL_ACTIVE = 6'h00;
  localparam logic [5:0] DSEL_PQ     = 6'h01;
  localparam logic [5:0] DSEL_VALID  = 6'h02;
  localparam logic [5:0] DSEL_DROP   = 6'h03;
  localparam logic [5:0] DSEL_END    = 6'h04;
  typedef enum logic [2:0] {
    ST_HUNT, ST_LEN, ST_ADDR, ST_PAYLOAD, ST_TAIL, ST_STAT2
  } rpf_state_t;
endpackage
`default_nettype wire

// File: rpf_preamble_qual.sv
`timescale 1ns/100ps
`default_nettype none
module rpf_preamble_qual import rpf_pkg::*; (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       restart,
  input  wire logic       bitValid,
  input  wire logic       bitIn,
  input  wire logic [2:0] threshold,
  output var  logic       qualityMet
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       prev_q;
  logic       prev_d;

  // ==========================================================
  // counter
  always_comb begin
    cnt_d  = cnt_q;
    prev_d = prev_q;
    if (restart) begin
      cnt_d  = 8'h00;
      prev_d = 1'b0;
    end else if (bitValid) begin
      prev_d = bitIn;
      if (bitIn != prev_q) begin
        // held at the top so a long preamble cannot wrap to zero
        if (cnt_q != PQ_MAX) cnt_d = cnt_q + PQ_UP;
      end else if (cnt_q < PQ_DOWN) begin
        cnt_d = 8'h00;
      end else begin
        cnt_d = cnt_q - PQ_DOWN;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q  <= 8'h00;
      prev_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      prev_q <= prev_d;
    end
  end

  assign qualityMet = cnt_q >= {3'h0, threshold, 2'h0};

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_pq_step_up: assert property (
    (!restart && bitValid && bitIn != prev_q && cnt_q != PQ_MAX)
      |=> cnt_q == $past(cnt_q) + PQ_UP)
    else $error("quality count did not rise by one");
  a_pq_floor: assert property (
    (!restart && bitValid && bitIn == prev_q && cnt_q < PQ_DOWN)
      |=> cnt_q == 8'h00)
    else $error("quality count did not stop at zero");
  a_pq_step_down: assert property (
    (!restart && bitValid && bitIn == prev_q && cnt_q >= PQ_DOWN)
      |=> cnt_q == $past(cnt_q) - PQ_DOWN)
    else $error("quality count did not fall by eight");
endmodule
`default_nettype wire

// File: rpf_radio_tx.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// far transmitter, seen after the demodulator on ref_clk
module rpf_radio_tx (
  input  wire logic       ref_clk,
  output var  logic       rxStart,
  output var  logic       rxBitValid,
  output var  logic       rxBit,
  output var  logic [7:0] rssiValue,
  output var  logic [6:0] lqiValue,
  output var  logic       crcOk
);
  int gap = 1;
  initial begin
    rxStart = 1'b0;
    rxBitValid = 1'b0;
    rxBit = 1'b0;
    rssiValue = 8'h5a;
    lqiValue = 7'h33;
    crcOk = 1'b1;
  end
  task automatic begin_rx();
    @(posedge ref_clk);
    rxStart <= 1'b1;
    @(posedge ref_clk);
    rxStart <= 1'b0;
  endtask
  // msb first; between bits the line shows the inverse, not a stale value
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge ref_clk);
      rxBit <= b[i];
      rxBitValid <= 1'b1;
      @(posedge ref_clk);
      rxBitValid <= 1'b0;
      rxBit <= ~b[i];
      repeat (gap) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// File: radio_packet_filter_config_bench.sv
`timescale 1ns/100ps
`default_nettype none
module radio_packet_filter_config_bench import rpf_pkg::*; ;
  typedef logic [7:0] rpf_bytes_t[$];
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, rxStart, rxBitValid, rxBit, crcOk;
  logic [7:0]  rssiValue, rxData;
  logic [6:0]  lqiValue;
  logic        rxDataValid, rxPacketEnd, rxDrop, debugDriveMax;
  logic        debugPinC, debugPinB, debugPinA;
  int          errTotal = 0;
  int          cmpCount = 0;
  int          drops = 0;
  int          pulses = 0;
  rpf_bytes_t  got;
  rpf_bytes_t  none;

  always #12.5 ref_clk = ~ref_clk;

  rpf_radio_tx tx (.ref_clk(ref_clk), .rxStart(rxStart),
    .rxBitValid(rxBitValid), .rxBit(rxBit), .rssiValue(rssiValue),
    .lqiValue(lqiValue), .crcOk(crcOk));
  rpf_packet_filter dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxStart(rxStart), .rxBitValid(rxBitValid), .rxBit(rxBit),
    .rssiValue(rssiValue), .lqiValue(lqiValue), .crcOk(crcOk),
    .rxData(rxData), .rxDataValid(rxDataValid), .rxPacketEnd(rxPacketEnd),
    .rxDrop(rxDrop), .debugPinC(debugPinC), .debugPinB(debugPinB),
    .debugPinA(debugPinA), .debugDriveMax(debugDriveMax));

  always @(posedge ref_clk) begin
    if (rxDataValid === 1'b1)
      got.push_back(rxData);
    if (rxDrop === 1'b1)
      drops++;
    if (debugPinA === 1'b1)
      pulses++;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    cmpCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a hung access
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("read data upper bytes", 32'h0, {8'h0, rd[31:8]});
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rdchk(input string n, input logic [15:0] idx,
                       input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 8'h00, r, e);
    check(n, {24'h0, exp}, r);
  endtask
  task automatic send_pkt(input rpf_bytes_t pk, input rpf_bytes_t ex,
                          input int exDrops);
    got.delete();
    drops = 0;
    tx.begin_rx();
    foreach (pk[i]) tx.send_byte(pk[i]);
    repeat (12) @(posedge ref_clk);
    check("byte count", 32'(ex.size()), 32'(got.size()));
    foreach (ex[i]) if (i < got.size()) check("byte", {24'h0, ex[i]},
                                              {24'h0, got[i]});
    check("drops", 32'(exDrops), 32'(drops));
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rdchk("sync high", IDX_SYNC_HI, 8'hd3);
    rdchk("sync low", IDX_SYNC_LO, 8'h91);
    rdchk("length", IDX_PKT_LEN, 8'hff);
    rdchk("filter", IDX_FILT_CTRL, 8'h04);
    rdchk("address", IDX_DEV_ADDR, 8'h00);
    rdchk("pin c", IDX_DBG_C, 8'h00);
    rdchk("pin b", IDX_DBG_B, 8'h00);
    rdchk("pin a", IDX_DBG_A, 8'h00);
    wr(IDX_FILT_CTRL, 8'hff);
    rdchk("filter mask", IDX_FILT_CTRL, 8'he7);
    wr(IDX_DBG_C, 8'hff);
    rdchk("pin c mask", IDX_DBG_C, 8'h7f);
    wr(IDX_DBG_B, 8'hff);
    rdchk("pin b mask", IDX_DBG_B, 8'hff);
    apb(1'b0, 16'hdf06, 8'h00, r, e);
    check("unmapped error", 32'h1, {31'h0, e});
    wr(IDX_FILT_CTRL, 8'h04);
  endtask
  task automatic t_debug();
    wr(IDX_DBG_C, 8'h40);
    wr(IDX_DBG_B, 8'hc0);
    wr(IDX_DBG_A, 8'h40);
    repeat (3) @(posedge ref_clk);
    check("pins inverted", 32'hf, {28'h0, debugPinC, debugPinB, debugPinA,
                                   debugDriveMax});
    wr(IDX_DBG_C, 8'h00);
    wr(IDX_DBG_B, 8'h00);
    wr(IDX_DBG_A, 8'h02);
    repeat (3) @(posedge ref_clk);
    check("pins plain", 32'h0, {28'h0, debugPinC, debugPinB, debugPinA,
                                debugDriveMax});
  endtask
  task automatic t_fixed();
    wr(IDX_LEN_CTRL, 8'h00);
    wr(IDX_PKT_LEN, 8'h03);
    pulses = 0;
    send_pkt('{8'hd3, 8'h91, 8'h11, 8'h22, 8'h33},
             '{8'h11, 8'h22, 8'h33, 8'h5a, 8'hb3}, 0);
    check("valid on pin", 32'd5, 32'(pulses));
    wr(IDX_DBG_A, 8'h00);
  endtask
  task automatic t_filter();
    logic [7:0] ad[4] = '{8'h42, 8'h00, 8'hff, 8'h17};
    rpf_bytes_t pk;
    rpf_bytes_t ex;
    bit         ok;
    wr(IDX_LEN_CTRL, 8'h01);
    wr(IDX_PKT_LEN, 8'hff);
    wr(IDX_DEV_ADDR, 8'h42);
    for (int m = 0; m < 4; m++) begin
      wr(IDX_FILT_CTRL, 8'(m));
      foreach (ad[i]) begin
        ok = (m == 0) || (ad[i] == 8'h42) || (m >= 2 && ad[i] == 8'h00)
             || (m == 3 && ad[i] == 8'hff);
        pk = '{8'hd3, 8'h91, 8'h02, ad[i], 8'h5c};
        ex = pk[2:4];
        if (!ok)
          ex.delete();
        send_pkt(pk, ex, ok ? 0 : 1);
      end
    end
  endtask
  task automatic t_length();
    wr(IDX_FILT_CTRL, 8'h00);
    wr(IDX_PKT_LEN, 8'h03);
    // sticky drop flag still holds the drops of the filter scenario
    wr(IDX_RX_STAT, 8'h00);
    rdchk("status cleared", IDX_RX_STAT, 8'h02);
    send_pkt('{8'hd3, 8'h91, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04},
             none, 1);
    rdchk("status drop seen", IDX_RX_STAT, 8'h06);
    send_pkt('{8'hd3, 8'h91, 8'h03, 8'h01, 8'h02, 8'h03},
             '{8'h03, 8'h01, 8'h02, 8'h03}, 0);
  endtask
  task automatic t_quality();
    tx.gap = 3;
    wr(IDX_SYNC_HI, 8'ha5);
    wr(IDX_SYNC_LO, 8'h5a);
    wr(IDX_FILT_CTRL, 8'he0);
    send_pkt('{8'haa, 8'haa, 8'haa, 8'haa, 8'ha5, 8'h5a, 8'h01, 8'h77},
             '{8'h01, 8'h77}, 0);
    wr(IDX_FILT_CTRL, 8'h20);
    // a good preamble, then a restart: its count must not carry over
    tx.begin_rx();
    repeat (4) tx.send_byte(8'haa);
    send_pkt('{8'ha5, 8'h5a, 8'h01, 8'h77}, none, 0);
    wr(IDX_FILT_CTRL, 8'h00);
    send_pkt('{8'ha5, 8'h5a, 8'h01, 8'h77}, '{8'h01, 8'h77}, 0);
  endtask

  // ==========================================================
  // run control
  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs();
    t_debug();
    t_fixed();
    t_filter();
    t_length();
    t_quality();
    giveVerdict();
  end
  // whole run needs well under 6000 cycles
  initial begin
    repeat (30000) @(posedge ref_clk);
    errTotal++;
    giveVerdict();
  end
endmodule
`default_nettype wire
